//--- hdl/xpd_combiner.sv
// Combiner end: sends 16 bytes per frame, mirrors them into its selector.
// Assumes a frame request is a one-cycle pulse on REF_CLK.
`timescale 1ns/1ps
`default_nettype none
module xpd_combiner
	import xpd_pkg::*;
(
	input  wire logic        REF_CLK,    // 50 MHz system clock
	input  wire logic        RST,        // Sync reset, active high
	input  wire logic        START,      // Pulse: send a frame
	input  wire logic [7:0]  BYTE_IN [16],// Bytes, index 15 = output 16
	input  wire logic        VT_REQ,     // Level: vertical trigger
	output logic             BUSY,       // Frame in progress
	output logic [127:0]     SELECTOR,   // Selector parallel outputs
	output logic             COMBINER_SHIFT_CLK, // Selector shift pulse
	xpd_link_if.host         LNK          // Serial control link
);
	typedef enum logic [1:0] {XPD_IDLE, XPD_SEND, XPD_END} xpd_state_e;
	xpd_state_e state;
	logic [1:0]   div;
	logic         sclk;
	logic [6:0]   bit_idx;
	logic [127:0] sel_shift;
	logic         rise;
	logic         fall;
	logic [3:0]   byte_no;
	logic         vt_sync;
	logic [1:0]   rst_sr;
	logic         rst_run;

	// Link clock is made here, so no crossing is needed on this side
	assign rise    = (div == XPD_HALF_DIV - 2'h1) && !sclk;
	assign fall    = (div == XPD_HALF_DIV - 2'h1) && sclk;
	assign byte_no = 4'hF - bit_idx[6:3];

	// Link clock runs late in reset so the card's sync reset takes
	assign rst_run = RST && rst_sr[1];

	always_ff @(posedge REF_CLK) begin
		rst_sr <= {rst_sr[0], RST};
	end

	always_ff @(posedge REF_CLK) begin
		if (rst_run || (!RST && state != XPD_IDLE))
			div <= (div == XPD_HALF_DIV - 2'h1) ? 2'h0 : div + 2'h1;
		else
			div <= 2'h0;
	end

	// One rise after the frame with strobe low flushes the last load
	always_ff @(posedge REF_CLK) begin
		if (rst_run || (!RST && state != XPD_IDLE)) begin
			if (rise || fall)
				sclk <= ~sclk;
		end else
			sclk <= 1'b0;
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			state   <= XPD_IDLE;
			bit_idx <= 7'h00;
		end else begin
			unique case (state)
			XPD_IDLE: begin
				bit_idx <= 7'h00;
				if (START)
					state <= XPD_SEND;
			end
			XPD_SEND: if (fall) begin
				bit_idx <= bit_idx + 7'h01;
				if (bit_idx == 7'h7F)
					state <= XPD_END;
			end
			XPD_END: if (div == XPD_HALF_DIV - 2'h1)
				state <= XPD_IDLE;
			endcase
		end
	end

	// Data changes on falling edge; card samples on rising edge
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			LNK.ctl_serial_in    <= 1'b0;
			LNK.ctl_frame_strobe <= 1'b0;
		end else begin
			LNK.ctl_frame_strobe <= state == XPD_SEND;
			LNK.ctl_serial_in <=
				BYTE_IN[byte_no][3'h7 - bit_idx[2:0]];
		end
	end
	assign LNK.ctl_shift_clk = sclk;

	// Selector mirrors the outgoing stream
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			sel_shift          <= 128'h0;
			COMBINER_SHIFT_CLK <= 1'b0;
		end else begin
			COMBINER_SHIFT_CLK <= rise && state == XPD_SEND;
			if (rise && state == XPD_SEND)
				sel_shift <= {sel_shift[126:0], LNK.ctl_serial_in};
		end
	end

	xpd_sync2 u_vt (
		.clk (REF_CLK),
		.rst (RST),
		.d   (VT_REQ),
		.q   (vt_sync)
	);

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			SELECTOR              <= 128'h0;
			LNK.vertical_trigger  <= 1'b0;
		end else begin
			LNK.vertical_trigger <= vt_sync;
			if (vt_sync && !LNK.vertical_trigger)
				SELECTOR <= sel_shift;
		end
	end

	assign BUSY = state != XPD_IDLE;
endmodule // xpd_combiner
`default_nettype wire

//--- hdl/xpd_pkg.sv
// Constants shared by the crosspoint serial control ends.
// Assumes both ends compile this package first.
package xpd_pkg;
	localparam int XPD_BYTE_BITS   = 8;
	localparam int XPD_OUTPUTS     = 16;
	localparam int XPD_ELEMENTS    = 6;
	localparam int XPD_CODE_MSB    = 7;
	localparam int XPD_CODE_LSB    = 6;
	localparam int XPD_GROUP_MSB   = 5;
	localparam int XPD_GROUP_LSB   = 4;
	localparam logic [1:0] XPD_GROUP_OFF = 2'h3;
	localparam logic [2:0] XPD_BIT_DEC   = 3'h2;
	localparam logic [2:0] XPD_BIT_LOAD  = 3'h7;
	localparam logic [3:0] XPD_ADDR_RST  = 4'h0;
	localparam logic [7:0] XPD_OFF_BYTE  = 8'h30;
	// Host divides REF_CLK by 2*XPD_HALF_DIV for the link clock
	localparam logic [1:0] XPD_HALF_DIV  = 2'h2;
endpackage

//--- hdl/xpd_link_if.sv
// Link between combiner processor end and one crosspoint card.
// Assumes the bench ties the card identity per slot.
`timescale 1ns/1ps
`default_nettype none
interface xpd_link_if;
	logic       ctl_shift_clk;
	logic       ctl_serial_in;
	logic       ctl_frame_strobe;
	logic       vertical_trigger;
	logic [1:0] card_identity;
	modport host (output ctl_shift_clk, output ctl_serial_in,
		output ctl_frame_strobe, output vertical_trigger);
	modport card (input ctl_shift_clk, input ctl_serial_in,
		input ctl_frame_strobe, input vertical_trigger,
		input card_identity);
endinterface
`default_nettype wire

//--- hdl/xpd_sync2.sv
// Two-flop synchroniser for a level.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module xpd_sync2 (
	input  wire logic clk,   // Destination clock
	input  wire logic rst,   // Synchronous reset
	input  wire logic d,     // Async level
	output logic      q      // Synchronised level
);
	logic meta;
	always_ff @(posedge clk) begin
		if (rst) begin
			meta <= 1'b0;
			q    <= 1'b0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule // xpd_sync2

//--- hdl/xpd_card.sv
// Crosspoint card decoder, runs on the link shift clock.
// Assumes the combiner keeps the strobe low between frames.
`timescale 1ns/1ps
`default_nettype none
module xpd_card
	import xpd_pkg::*;
(
	xpd_link_if.card    LNK,                   // Serial control link
	input  wire logic   RST,                   // Sync reset, link domain
	output logic [5:0]  ELEMENT_DISABLE,       // Per-element disables
	output logic [2:0]  ELEMENT_INPUT_INDEX,   // Input within element
	output logic [3:0]  ELEMENT_OUTPUT_ADDRESS,// Output being loaded
	output logic        ELEMENT_LOAD,          // Latch strobe, one cycle
	output logic        CARD_VERTICAL_TRIGGER  // Trigger forwarded
);
	// ********************************
	// Shift and counters
	// ********************************
	logic [7:0] shifter;
	logic [2:0] bit_cnt;
	logic [3:0] out_addr;
	logic [7:0] next_byte;
	logic       clk;

	assign clk       = LNK.ctl_shift_clk;
	assign next_byte = {shifter[6:0], LNK.ctl_serial_in};

	always_ff @(posedge clk) begin
		if (RST)
			shifter <= 8'h00;
		else if (LNK.ctl_frame_strobe)
			shifter <= next_byte;
	end

	always_ff @(posedge clk) begin
		if (RST || !LNK.ctl_frame_strobe)
			bit_cnt <= 3'h0;
		else
			bit_cnt <= bit_cnt + 3'h1;
	end

	// Outputs run 16 down to 1; 0-1 wraps to 15 = output 16
	always_ff @(posedge clk) begin
		if (RST || !LNK.ctl_frame_strobe)
			out_addr <= XPD_ADDR_RST;
		else if (bit_cnt == XPD_BIT_DEC)
			out_addr <= out_addr - 4'h1;
	end

	// ********************************
	// Byte decode
	// ********************************
	logic       match;
	logic [1:0] grp;
	logic [5:0] next_dis;

	assign grp   = next_byte[XPD_GROUP_MSB:XPD_GROUP_LSB];
	assign match = (next_byte[XPD_CODE_MSB:XPD_CODE_LSB]
		^ LNK.card_identity) == 2'h0;

	// Element = group*2 + bit 3 of input number
	always_comb begin
		next_dis = 6'h00;
		if (match && grp != XPD_GROUP_OFF)
			next_dis[{grp, next_byte[3]}] = 1'b1;
	end

	// ********************************
	// Element latch
	// ********************************
	// Loaded while the eighth bit shifts in, so the latch sees a full byte
	always_ff @(posedge clk) begin
		if (RST) begin
			ELEMENT_DISABLE        <= 6'h00;
			ELEMENT_INPUT_INDEX    <= 3'h0;
			ELEMENT_OUTPUT_ADDRESS <= 4'h0;
			ELEMENT_LOAD           <= 1'b0;
		end else begin
			ELEMENT_LOAD <= LNK.ctl_frame_strobe
				&& bit_cnt == XPD_BIT_LOAD;
			if (LNK.ctl_frame_strobe && bit_cnt == XPD_BIT_LOAD) begin
				ELEMENT_DISABLE        <= next_dis;
				ELEMENT_INPUT_INDEX    <= next_byte[2:0];
				ELEMENT_OUTPUT_ADDRESS <= out_addr;
			end
		end
	end

	xpd_sync2 u_xpd_sync2 (
		.clk (clk),
		.rst (RST),
		.d   (LNK.vertical_trigger),
		.q   (CARD_VERTICAL_TRIGGER)
	);
endmodule // xpd_card
`default_nettype wire

//--- test/xpd_link_monitor.sv
// Checker on the link signals and the card's element outputs.
// Assumes the bench instantiates it beside the link interface.
`timescale 1ns/1ps
`default_nettype none
module xpd_link_monitor (
	input wire logic       REF_CLK,                // System clock
	input wire logic       RST,                    // Sync reset
	input wire logic       ctl_shift_clk,          // Link clock
	input wire logic       ctl_serial_in,          // Link data
	input wire logic       ctl_frame_strobe,       // Frame strobe
	input wire logic [1:0] card_identity,          // Card slot
	input wire logic [5:0] ELEMENT_DISABLE,        // Disables
	input wire logic [2:0] ELEMENT_INPUT_INDEX,    // Input index
	input wire logic [3:0] ELEMENT_OUTPUT_ADDRESS, // Output address
	input wire logic       ELEMENT_LOAD            // Load pulse
);
	logic [7:0] sh;
	logic [7:0] nb;
	logic       ok;
	// The host runs the link clock during reset, so a sync clear works
	always_ff @(posedge ctl_shift_clk) begin
		if (RST || !ctl_frame_strobe) nb <= 8'h00;
		else nb <= nb + 8'h01;
	end
	always_ff @(posedge ctl_shift_clk) begin
		if (ctl_frame_strobe) sh <= {sh[6:0], ctl_serial_in};
	end
	assign ok = sh[7:6] == card_identity && sh[5:4] != 2'h3;
	// ****
	// Link domain
	// ****
	chk_one_disable:
	assert property (@(posedge ctl_shift_clk) disable iff (RST)
		$onehot0(ELEMENT_DISABLE)) else $error("two disables on");
	chk_disable_decode:
	assert property (@(posedge ctl_shift_clk) disable iff (RST)
		ELEMENT_LOAD && ok |-> ELEMENT_DISABLE == 6'(1 << {sh[5:4], sh[3]}))
		else $error("wrong disable");
	chk_code_mismatch:
	assert property (@(posedge ctl_shift_clk) disable iff (RST)
		ELEMENT_LOAD && !ok |-> ELEMENT_DISABLE == 6'h00)
		else $error("disable on mismatch");
	chk_index_low:
	assert property (@(posedge ctl_shift_clk) disable iff (RST)
		ELEMENT_LOAD |-> ELEMENT_INPUT_INDEX == sh[2:0])
		else $error("wrong input index");
	chk_load_single:
	assert property (@(posedge ctl_shift_clk) disable iff (RST)
		ELEMENT_LOAD |=> !ELEMENT_LOAD) else $error("long load");
	chk_load_bitpos:
	assert property (@(posedge ctl_shift_clk) disable iff (RST)
		ELEMENT_LOAD |-> nb[2:0] == 3'h0 && nb != 8'h00)
		else $error("load off byte edge");
	chk_addr_down:
	assert property (@(posedge ctl_shift_clk) disable iff (RST)
		ELEMENT_LOAD |-> ELEMENT_OUTPUT_ADDRESS == 4'(8'h10 - (nb >> 3)))
		else $error("wrong output address");
	chk_strobe_gate:
	assert property (@(posedge ctl_shift_clk) disable iff (RST)
		ELEMENT_LOAD |-> $past(ctl_frame_strobe)) else $error("no strobe");
	// ****
	// System domain check, then covers on the link clock
	// ****
	chk_data_steady:
	assert property (@(posedge REF_CLK) disable iff (RST)
		ctl_shift_clk && $past(ctl_shift_clk) |-> $stable(ctl_serial_in))
		else $error("data moved while clock high");
	cov_match: cover property (@(posedge ctl_shift_clk) ELEMENT_LOAD && ok);
	cov_miss: cover property (@(posedge ctl_shift_clk) ELEMENT_LOAD && !ok);
	cov_last: cover property (@(posedge ctl_shift_clk)
		ELEMENT_LOAD && ELEMENT_OUTPUT_ADDRESS == 4'h0);
endmodule // xpd_link_monitor
`default_nettype wire

//--- test/crosspoint_serial_control_decoder_bench.sv
// Bench joining the combiner and one card across the link.
// Assumes the package and design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module crosspoint_serial_control_decoder_bench;
	import xpd_pkg::*;
	logic         REF_CLK = 1'b0;
	logic         RST = 1'b1;
	logic         START = 1'b0;
	logic         VT_REQ = 1'b0;
	logic [7:0]   BYTE_IN [16];
	logic         BUSY;
	logic [127:0] SELECTOR;
	logic [127:0] sel_exp = 128'h0;
	logic [5:0]   dis;
	logic [2:0]   idx;
	logic [3:0]   adr;
	logic         ld;
	logic         csc;
	logic         cvt;
	int           n_csc = 0;
	logic         bq [$];
	logic [12:0]  lq [$];
	int           n_fail = 0;
	int           tests_run = 0;
	xpd_link_if lnk();
	xpd_combiner u_xpd_combiner (.REF_CLK(REF_CLK), .RST(RST),
		.START(START), .BYTE_IN(BYTE_IN), .VT_REQ(VT_REQ), .BUSY(BUSY),
		.SELECTOR(SELECTOR), .COMBINER_SHIFT_CLK(csc), .LNK(lnk.host));
	xpd_card u_xpd_card (.LNK(lnk.card), .RST(RST), .ELEMENT_DISABLE(dis),
		.ELEMENT_INPUT_INDEX(idx), .ELEMENT_OUTPUT_ADDRESS(adr),
		.ELEMENT_LOAD(ld), .CARD_VERTICAL_TRIGGER(cvt));
	xpd_link_monitor u_xpd_link_monitor (.REF_CLK(REF_CLK), .RST(RST),
		.ctl_shift_clk(lnk.ctl_shift_clk), .ctl_serial_in(lnk.ctl_serial_in),
		.ctl_frame_strobe(lnk.ctl_frame_strobe),
		.card_identity(lnk.card_identity), .ELEMENT_DISABLE(dis),
		.ELEMENT_INPUT_INDEX(idx), .ELEMENT_OUTPUT_ADDRESS(adr),
		.ELEMENT_LOAD(ld));
	always #10 REF_CLK = ~REF_CLK;
	always @(posedge REF_CLK) if (csc === 1'b1) n_csc++;
	always @(posedge lnk.ctl_shift_clk) begin
		if (lnk.ctl_frame_strobe === 1'b1) bq.push_back(lnk.ctl_serial_in);
		if (ld === 1'b1) lq.push_back({adr, dis, idx});
	end
	task automatic check(input logic [127:0] got, input logic [127:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// ****
	// One frame; a second start mid-frame must be ignored
	// ****
	task automatic frame(input logic [1:0] s, input logic [1:0] id);
		logic [7:0] b;
		logic [5:0] d;
		int         k;
		lnk.card_identity = id;
		n_csc = 0;
		bq.delete();
		lq.delete();
		for (k = 0; k < 16; k++) BYTE_IN[k] = {k[1:0] ^ s, k[3:2], k[3:0]};
		START = 1'b1;
		@(negedge REF_CLK) START = 1'b0;
		repeat (40) @(negedge REF_CLK);
		START = 1'b1;
		@(negedge REF_CLK) START = 1'b0;
		for (k = 0; k < 2000 && BUSY !== 1'b0; k++) @(negedge REF_CLK);
		repeat (10) @(negedge REF_CLK);
		check(bq.size(), 128);
		check(lq.size(), 16);
		check(n_csc, 128);
		check(cvt, VT_REQ);
		for (k = 0; k < 128; k++) check(bq[k], BYTE_IN[15-k/8][7-k%8]);
		for (k = 0; k < 16; k++) begin
			b = BYTE_IN[15-k];
			d = (b[7:6] == id && b[5:4] != 2'h3) ? 6'(1 << {b[5:4], b[3]}) : 0;
			check(lq[k], {4'(15 - k), d, b[2:0]});
		end
		check(SELECTOR, sel_exp);
	endtask
	task automatic vt();
		for (int k = 0; k < 16; k++) sel_exp[k*8 +: 8] = BYTE_IN[k];
		VT_REQ = 1'b1;
		repeat (8) @(negedge REF_CLK);
		check(SELECTOR, sel_exp);
		VT_REQ = 1'b0;
		repeat (4) @(negedge REF_CLK);
	endtask
	initial begin
		lnk.card_identity = 2'h0;
		for (int k = 0; k < 16; k++) BYTE_IN[k] = 8'h00;
		repeat (12) @(negedge REF_CLK);
		RST = 1'b0;
		@(negedge REF_CLK);
		frame(2'h0, 2'h0);
		vt();
		frame(2'h1, 2'h1);
		frame(2'h2, 2'h2);
		vt();
		frame(2'h3, 2'h1);
		final_report();
	end
	initial begin
		#400000;
		n_fail++;
		final_report();
	end
endmodule // crosspoint_serial_control_decoder_bench
`default_nettype wire
